// File: rtl/efg_pkg.sv
// constants, types and helpers of the external bus float gap inserter
package efg_pkg;
  localparam int          CS_COUNT        = 4;
  localparam int          CS_W            = 2;
  localparam int          GAP_W           = 3;
  localparam int          CNT_W           = 4;
  localparam int          DATA_W          = 16;
  localparam int          CFG_W           = CS_COUNT * GAP_W;
  localparam logic        PHASE_SETUP     = 1'b0;
  localparam logic        PHASE_STROBE    = 1'b1;
  localparam logic [3:0]  CS_NONE         = 4'hF;
  localparam logic [3:0]  CS_ONE          = 4'h1;
  localparam logic [GAP_W-1:0] GAP_ZERO   = 3'h0;
  localparam logic [GAP_W-1:0] GAP_ONE    = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACC} efg_state_e;

  // one bus cycle is two clock ticks; load value of a down counter ending at zero
  function automatic logic [CNT_W-1:0] gap_ticks(input logic [GAP_W-1:0] g);
    gap_ticks = {g, 1'b0} - CNT_ONE;
  endfunction

  function automatic logic [GAP_W-1:0] max_one(input logic [GAP_W-1:0] g);
    max_one = (g == GAP_ZERO) ? GAP_ONE : g;
  endfunction
endpackage

// File: rtl/efg_gap_if.sv
// carrier between the sequencer and the gap calculator
`timescale 1ns/1ps
`default_nettype none
interface efg_gap_if;
  import efg_pkg::*;
  logic                   prev_valid;
  logic                   prev_write;
  logic [CS_W-1:0]        prev_cs;
  logic [GAP_W-1:0]       prev_gap;
  logic                   next_write;
  logic [CS_W-1:0]        next_cs;
  logic                   early;
  logic [GAP_W-1:0]       gap;
  modport calc (input prev_valid, prev_write, prev_cs, prev_gap, next_write, next_cs, early,
                output gap);
  modport user (output prev_valid, prev_write, prev_cs, prev_gap, next_write, next_cs, early,
                input gap);
endinterface
`default_nettype wire

// File: rtl/efg_gap_calc.sv
// gap size from the previous and next access
`timescale 1ns/1ps
`default_nettype none
module efg_gap_calc
  import efg_pkg::*;
(
  efg_gap_if.calc gi
);
  always_comb begin
    if (!gi.prev_valid) begin
      gi.gap = GAP_ZERO;
    end else if (gi.prev_cs != gi.next_cs) begin
      if (gi.prev_write) begin
        gi.gap = GAP_ONE;
      end else begin
        gi.gap = max_one(gi.prev_gap);
      end
    end else if (gi.prev_write == gi.next_write) begin
      gi.gap = GAP_ZERO;
    end else if (gi.prev_write) begin
      gi.gap = gi.early ? GAP_ONE : GAP_ZERO;
    end else begin
      gi.gap = gi.prev_gap;
    end
  end
endmodule
`default_nettype wire

// File: rtl/efg_float_gap_insert.sv
// access sequencer with float gap insertion toward the external memories
`timescale 1ns/1ps
`default_nettype none
module efg_float_gap_insert
  import efg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [CS_W-1:0]   req_cs,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              early_read_select,
  input  wire logic [CFG_W-1:0]  programmed_gap_count,
  output logic [CS_COUNT-1:0]    chip_select_n,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n
);
  efg_gap_if gi ();

  efg_state_e         state_q, state_d;
  logic               phase_q, phase_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               rec_valid_q, rec_valid_d;
  logic               rec_write_q, rec_write_d;
  logic [CS_W-1:0]    rec_cs_q, rec_cs_d;
  logic [GAP_W-1:0]   rec_gap_q, rec_gap_d;
  logic               rec_early_q, rec_early_d;
  logic [DATA_W-1:0]  dout_q, dout_d;
  logic [CS_COUNT-1:0] cs_n_q, cs_n_d;
  logic               rd_n_q, rd_n_d;
  logic               wr_n_q, wr_n_d;
  logic               oe_n_q, oe_n_d;
  logic               take;
  logic [GAP_W-1:0]   req_gap;

  assign req_gap = programmed_gap_count[req_cs*GAP_W +: GAP_W];

  assign gi.prev_valid = rec_valid_q;
  assign gi.prev_write = rec_write_q;
  assign gi.prev_cs    = rec_cs_q;
  assign gi.prev_gap   = rec_gap_q;
  assign gi.next_write = req_write;
  assign gi.next_cs    = req_cs;
  assign gi.early      = early_read_select;

  efg_gap_calc u_calc (
    .gi (gi)
  );

  // a new access is taken when idle or in the last tick of the running access
  assign req_ready = (state_q == ST_IDLE) || (state_q == ST_ACC && phase_q == PHASE_STROBE);
  assign take      = req_valid && req_ready;

  always_comb begin
    state_d     = state_q;
    phase_d     = phase_q;
    cnt_d       = cnt_q;
    rec_valid_d = rec_valid_q;
    rec_write_d = rec_write_q;
    rec_cs_d    = rec_cs_q;
    rec_gap_d   = rec_gap_q;
    rec_early_d = rec_early_q;
    dout_d      = dout_q;
    if (take) begin
      rec_valid_d = 1'b1;
      rec_write_d = req_write;
      rec_cs_d    = req_cs;
      rec_gap_d   = req_gap;
      rec_early_d = early_read_select;
      dout_d      = req_wdata;
      phase_d     = PHASE_SETUP;
      if (gi.gap == GAP_ZERO) begin
        state_d = ST_ACC;
      end else begin
        state_d = ST_GAP;
        cnt_d   = gap_ticks(gi.gap);
      end
    end else begin
      case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_GAP: begin
          if (cnt_q == CNT_ZERO) begin
            state_d = ST_ACC;
            phase_d = PHASE_SETUP;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        ST_ACC: begin
          if (phase_q == PHASE_SETUP) begin
            phase_d = PHASE_STROBE;
          end else begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // pin levels follow the next state so that they leave flip-flops aligned to it
  always_comb begin
    cs_n_d = CS_NONE;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    oe_n_d = 1'b1;
    if (state_d == ST_ACC) begin
      cs_n_d = ~(CS_ONE << rec_cs_d);
      if (rec_write_d) begin
        oe_n_d = 1'b0;
        wr_n_d = (phase_d != PHASE_STROBE);
      end else begin
        rd_n_d = !(rec_early_d || phase_d == PHASE_STROBE);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      phase_q     <= PHASE_SETUP;
      cnt_q       <= CNT_ZERO;
      rec_valid_q <= 1'b0;
      rec_write_q <= 1'b0;
      rec_cs_q    <= '0;
      rec_gap_q   <= GAP_ZERO;
      rec_early_q <= 1'b0;
      dout_q      <= '0;
      cs_n_q      <= CS_NONE;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
    end else begin
      state_q     <= state_d;
      phase_q     <= phase_d;
      cnt_q       <= cnt_d;
      rec_valid_q <= rec_valid_d;
      rec_write_q <= rec_write_d;
      rec_cs_q    <= rec_cs_d;
      rec_gap_q   <= rec_gap_d;
      rec_early_q <= rec_early_d;
      dout_q      <= dout_d;
      cs_n_q      <= cs_n_d;
      rd_n_q      <= rd_n_d;
      wr_n_q      <= wr_n_d;
      oe_n_q      <= oe_n_d;
    end
  end

  assign chip_select_n  = cs_n_q;
  assign read_strobe_n  = rd_n_q;
  assign write_strobe_n = wr_n_q;
  assign data_out       = dout_q;
  assign data_oe_n      = oe_n_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_std_read_cycle;
    rd_n_q ##1 !rd_n_q;
  endsequence

  sequence s_gap_done;
    state_q == ST_ACC && phase_q == PHASE_SETUP;
  endsequence

  chk_same_type_zero: assert property (take && rec_valid_q && rec_cs_q == req_cs &&
      rec_write_q == req_write |-> gi.gap == GAP_ZERO ##1 state_q == ST_ACC)
    else $error("same type on same select got a gap");
  chk_rd_wr_same: assert property (take && rec_valid_q && rec_cs_q == req_cs &&
      !rec_write_q && req_write |=> (state_q == ST_ACC) == ($past(rec_gap_q) == GAP_ZERO) &&
      (state_q == ST_ACC || cnt_q == gap_ticks($past(rec_gap_q))))
    else $error("read to write gap differs from programmed count");
  chk_wr_rd_same: assert property (take && rec_valid_q && rec_cs_q == req_cs &&
      rec_write_q && !req_write |-> gi.gap == (early_read_select ? GAP_ONE : GAP_ZERO))
    else $error("write to read gap wrong for read mode");
  chk_rd_other_cs: assert property (take && rec_valid_q && rec_cs_q != req_cs &&
      !rec_write_q |-> gi.gap == max_one(rec_gap_q) && gi.gap != GAP_ZERO)
    else $error("read then other select gap wrong");
  chk_wr_other_cs: assert property (take && rec_valid_q && rec_cs_q != req_cs &&
      rec_write_q |=> state_q == ST_GAP && cnt_q == CNT_ONE ##2 s_gap_done)
    else $error("write then other select did not insert one cycle");
  chk_gap_quiet: assert property (state_q == ST_GAP |-> cs_n_q == CS_NONE && rd_n_q &&
      wr_n_q && oe_n_q)
    else $error("bus active during float gap");
  chk_gap_to_acc: assert property (state_q == ST_GAP && cnt_q == CNT_ZERO && !take |=>
      s_gap_done)
    else $error("gap did not end in an access");
  chk_std_read: assert property (state_q == ST_ACC && phase_q == PHASE_SETUP &&
      !rec_write_q && !rec_early_q |-> s_std_read_cycle)
    else $error("standard read strobe not in second half");
  chk_early_read: assert property (state_q == ST_ACC && !rec_write_q && rec_early_q |->
      !rd_n_q && cs_n_q != CS_NONE)
    else $error("early read strobe not held");
  chk_record: assert property (take |=> rec_valid_q && rec_cs_q == $past(req_cs) &&
      rec_write_q == $past(req_write) && rec_early_q == $past(early_read_select))
    else $error("last access record not updated");
  chk_drv_release: assert property (state_q == ST_ACC && rec_write_q |-> !oe_n_q ##0
      (phase_q == PHASE_STROBE) == !wr_n_q)
    else $error("write drive or strobe misaligned");
  chk_wr_rd_early: assert property (take && rec_valid_q && rec_write_q &&
      rec_cs_q == req_cs && !req_write && early_read_select |=>
      state_q == ST_GAP ##2 s_gap_done)
    else $error("write to early read did not insert one cycle");
  chk_wr_rd_std: assert property (take && rec_valid_q && rec_write_q &&
      rec_cs_q == req_cs && !req_write && !early_read_select |=> s_gap_done)
    else $error("write to standard read inserted a gap");
  chk_rd_other_min: assert property (take && rec_valid_q && !rec_write_q &&
      rec_cs_q != req_cs && rec_gap_q == GAP_ZERO |=>
      state_q == ST_GAP ##2 s_gap_done)
    else $error("read then other select with zero count did not insert one cycle");
  chk_early_hold: assert property (take && state_q == ST_ACC && rec_early_q &&
      !rec_write_q && !req_write && req_cs == rec_cs_q && early_read_select |=>
      !rd_n_q && $stable(cs_n_q))
    else $error("early read strobe dropped between reads");
  chk_gap_refused: assert property (state_q == ST_GAP ||
      state_q == ST_ACC && phase_q == PHASE_SETUP |-> !req_ready)
    else $error("request accepted inside an access or gap");
  chk_idle_pins: assert property (state_q == ST_IDLE |-> cs_n_q == CS_NONE &&
      rd_n_q && wr_n_q && oe_n_q)
    else $error("bus active or driven while idle");
endmodule
`default_nettype wire

// File: dv/efg_mem_model.sv
// external memory model that flags data bus contention
`timescale 1ns/1ps
`default_nettype none
module efg_mem_model
  import efg_pkg::*;
(
  input  wire logic [CS_COUNT-1:0] chip_select_n,
  input  wire logic                read_strobe_n,
  input  wire logic                data_oe_n,
  output logic                     bus_clash
);
  logic mem_drive;
  // a selected memory drives the data lines while its read strobe is low
  assign mem_drive = (chip_select_n != CS_NONE) && !read_strobe_n;
  assign bus_clash = mem_drive && !data_oe_n;
endmodule
`default_nettype wire

// File: dv/ext_bus_float_gap_insert_tb.sv
// self-checking bench of the float gap inserter
`timescale 1ns/1ps
`default_nettype none
module ext_bus_float_gap_insert_tb;
  import efg_pkg::*;
  logic                clk;
  logic                nrst;
  logic                req_valid;
  logic                req_ready;
  logic                req_write;
  logic [CS_W-1:0]     req_cs;
  logic [DATA_W-1:0]   req_wdata;
  logic                early_read_select;
  logic [CFG_W-1:0]    programmed_gap_count;
  logic [CS_COUNT-1:0] chip_select_n;
  logic                read_strobe_n;
  logic                write_strobe_n;
  logic [DATA_W-1:0]   data_out;
  logic                data_oe_n;
  logic                bus_clash;
  int                  n_fail;
  int                  checks_done;
  logic                pv;
  logic                pw;
  logic [CS_W-1:0]     pcs;
  logic [GAP_W-1:0]    pg;

  efg_float_gap_insert i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_cs(req_cs), .req_wdata(req_wdata),
    .early_read_select(early_read_select), .programmed_gap_count(programmed_gap_count),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe_n(data_oe_n));
  efg_mem_model i_mem (.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .data_oe_n(data_oe_n), .bus_clash(bus_clash));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // gap in bus cycles from the recorded previous access
  function automatic int exp_gap(logic w, logic [CS_W-1:0] cs, logic e);
    if (!pv) return 0;
    if (pcs == cs) return (pw == w) ? 0 : (pw ? int'(e) : int'(pg));
    return pw ? 1 : ((pg == GAP_ZERO) ? 1 : int'(pg));
  endfunction

  // pins as {cs_n, rd_n, wr_n, oe_n}; phase 0 idle, 1 setup, 2 strobe
  function automatic logic [6:0] exp_pins(int ph, logic w, logic [CS_W-1:0] cs, logic e);
    if (ph == 0) return 7'h7F;
    if (ph == 1) return {~(CS_ONE << cs), w | ~e, 1'b1, ~w};
    return {~(CS_ONE << cs), w, ~w, ~w};
  endfunction

  task automatic cmp_pins(logic [6:0] exp);
    logic [7:0] got;
    got = {bus_clash, chip_select_n, read_strobe_n, write_strobe_n, data_oe_n};
    checks_done++;
    if (got !== {1'b0, exp}) begin
      n_fail++;
      $display("Error at %0t: pins %0h expected %0h", $time, got, {1'b0, exp});
    end
  endtask

  task automatic cmp_ready(logic exp);
    checks_done++;
    if (req_ready !== exp) begin
      n_fail++;
      $display("Error at %0t: ready %0h expected %0h", $time, req_ready, exp);
    end
  endtask

  task automatic cmp_data(logic [DATA_W-1:0] exp);
    checks_done++;
    if (data_out !== exp) begin
      n_fail++;
      $display("Error at %0t: data %0h expected %0h", $time, data_out, exp);
    end
  endtask

  task automatic acc(logic w, logic [CS_W-1:0] cs, logic e, logic [CFG_W-1:0] cfg);
    int g;
    int k;
    logic [DATA_W-1:0] d;
    d = DATA_W'($urandom);
    req_valid = 1'b1;
    req_write = w;
    req_cs = cs;
    req_wdata = d;
    early_read_select = e;
    programmed_gap_count = cfg;
    #1;
    k = 0;
    while (req_ready !== 1'b1 && k < 40) begin
      @(negedge clk);
      #1;
      k++;
    end
    if (req_ready !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: ready %0h expected %0h", $time, req_ready, 1'b1);
    end
    g = exp_gap(w, cs, e);
    pv = 1'b1;
    pw = w;
    pcs = cs;
    pg = cfg[GAP_W*cs +: GAP_W];
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req_write = ~w;
    req_cs = ~cs;
    req_wdata = ~d;
    repeat (2 * g) begin
      cmp_pins(7'h7F);
      cmp_ready(1'b0);
      @(negedge clk);
    end
    cmp_pins(exp_pins(1, w, cs, e));
    cmp_ready(1'b0);
    @(negedge clk);
    cmp_pins(exp_pins(2, w, cs, e));
    cmp_ready(1'b1);
    if (w) cmp_data(d);
  endtask

  task automatic do_reset(int n);
    nrst = 1'b0;
    pv = 1'b0;
    repeat (n) @(negedge clk);
    cmp_pins(7'h7F);
    cmp_ready(1'b1);
    nrst = 1'b1;
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    logic [GAP_W-1:0] gv;
    {nrst, req_valid, req_write, req_cs, req_wdata} = '0;
    {early_read_select, programmed_gap_count, pv, pw, pcs, pg} = '0;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h73422D74));
    do_reset(12);
    @(negedge clk);
    // every pair of types, same or other select, counts 0 1 2 7, both modes
    for (int c = 0; c < 64; c++) begin
      gv = (c[4:3] == 2'h3) ? 3'h7 : {1'b0, c[4:3]};
      acc(c[0], 2'h1, c[5], {4{gv}});
      acc(c[1], c[2] ? 2'h1 : 2'h2, c[5], {4{gv}});
    end
    do_reset(2);
    repeat (300) begin
      acc(1'($urandom), CS_W'($urandom), 1'($urandom), CFG_W'($urandom));
      repeat ($urandom_range(0, 2)) @(negedge clk);
    end
    give_verdict();
  end

  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
